// ==== rtl/dcs_core.sv ====
`timescale 1ns/1ps
module dcs_core (
	input  wire logic           clk_sys,
	input  wire logic           rst_n,
	input  wire dcs_pkg::dcs_pa_t  pa,
	input  wire dcs_pkg::dcs_ctl_t ctl,
	input  wire logic [15:0]    rd_data,
	input  wire logic [31:0]    acc,
	output logic [15:0]         program_address_bus_q,
	output logic [15:0]         next_pa_q,
	output logic [15:0]         program_counter_q,
	output logic [15:0]         micro_stack_q,
	output logic [15:0]         stack_top_q,
	output logic                trap_taken_q,
	output logic [15:0]         temporary_operand_register_q,
	output logic [31:0]         product_register_q,
	output logic [31:0]         product_to_alu_q,
	output logic [31:0]         input_scaled_q,
	output logic [15:0]         data_write_bus_q,
	output logic                data_write_en_q,
	output logic [15:0]         status_word_0_q,
	output logic [15:0]         status_word_1_q,
	output logic                external_flag_output_q
);
	import dcs_pkg::*;

	function automatic logic [31:0] isc_f(input logic [15:0] d, input logic [4:0] n, input logic sx);
		logic [31:0] e;
		logic [4:0]  c;
		e = {{16{sx & d[15]}}, d};
		c = (n > ISC_MAX) ? ISC_MAX : n;
		isc_f = e << c;
	endfunction

	function automatic logic [31:0] psc_f(input logic [31:0] p, input logic [1:0] pm);
		case (pm)
			PM_NONE: psc_f = p;
			PM_L1:   psc_f = p << PS_L1;
			PM_L4:   psc_f = p << PS_L4;
			default: psc_f = $signed(p) >>> PS_R6;
		endcase
	endfunction

	// {word select, bit index} for a control bit
	function automatic logic [4:0] cbit_f(input dcs_cbit_t b);
		case (b)
			CB_OVM:  cbit_f = {1'b0, 4'(ST0_OVM)};
			CB_INTERRUPT_DISABLE_BIT: cbit_f = {1'b0, 4'(ST0_INTERRUPT_DISABLE_BIT)};
			CB_CNF:  cbit_f = {1'b1, 4'(ST1_CNF)};
			CB_TC:   cbit_f = {1'b1, 4'(ST1_TC)};
			CB_SXM:  cbit_f = {1'b1, 4'(ST1_SXM)};
			CB_C:    cbit_f = {1'b1, 4'(ST1_C)};
			default: cbit_f = {1'b1, 4'(ST1_XF)};
		endcase
	endfunction

	logic [15:0] stk_q [STK_DEPTH];
	dcs_pmode_t  pmode_q;
	dcs_pmode_t  pmode_d;
	logic [15:0] npa_d;
	logic [15:0] par_d;
	logic [15:0] st0_d;
	logic [15:0] st1_d;
	logic [15:0] dw_d;
	logic        stk_push;
	logic [15:0] stk_val;

	wire         interrupt_disable_bit      = status_word_0_q[ST0_INTERRUPT_DISABLE_BIT];
	wire         sign_extension_mode       = status_word_1_q[ST1_SXM];
	wire [1:0]   pm        = status_word_1_q[1:0];
	// maskable traps wait while interrupts are disabled
	wire         trap_ok   = pa.trap & ~pa.bus_hold & (~pa.trap_maskable | ~interrupt_disable_bit);
	wire [15:0]  trap_vec  = TRAP_BASE + (16'(pa.trap_num) << TRAP_SHIFT);
	wire         seq_end   = pa.dseq_end & (pmode_q == PMODE_DATA);
	wire [4:0]   cpos      = cbit_f(ctl.cbit);
	wire [4:0]   isc_n     = ctl.isc_by_temporary_operand_register ? {1'b0, temporary_operand_register_q[3:0]} : ctl.isc_cnt;
	wire [31:0]  isc_res   = isc_f(rd_data, isc_n, sign_extension_mode);
	wire [3:0]   dynamic_bit_test_instruction_idx  = 4'hf - temporary_operand_register_q[3:0];
	wire [16:0]  mpa       = {~ctl.mpy_unsigned & temporary_operand_register_q[15], temporary_operand_register_q};
	wire [16:0]  mpb       = {~ctl.mpy_unsigned & rd_data[15], rd_data};
	wire [33:0]  mpy_full  = 34'($signed(mpa) * $signed(mpb));
	wire [31:0]  osc_sh    = acc << ctl.osc_cnt;
	wire [15:0]  osc_out   = ctl.store_hi ? osc_sh[31:16] : osc_sh[15:0];

	// trap beats branch beats data-sequence entry; hold freezes the next address and fetch/data mode
	always_comb begin
		pmode_d = pmode_q;
		npa_d   = program_counter_q;
		if (trap_ok) begin
			npa_d = trap_vec;
		end else if (pa.branch) begin
			npa_d = pa.br_addr;
		end else if (pa.dseq_start) begin
			npa_d   = pa.dseq_addr;
			pmode_d = PMODE_DATA;
		end else if (seq_end) begin
			npa_d   = micro_stack_q;
			pmode_d = PMODE_FETCH;
		end
		if (pa.bus_hold) begin
			npa_d   = next_pa_q;
			pmode_d = pmode_q;
		end
	end

	assign par_d    = pa.bus_hold ? program_address_bus_q : next_pa_q;
	assign stk_push = trap_ok | pa.push;
	assign stk_val  = trap_ok ? program_counter_q : pa.push_data;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			program_address_bus_q <= RST_PA;
			next_pa_q             <= RST_PA;
			program_counter_q     <= RST_PA + 16'h0001;
			pmode_q               <= PMODE_FETCH;
			trap_taken_q          <= 1'b0;
		end else begin
			program_address_bus_q <= par_d;
			next_pa_q             <= npa_d;
			program_counter_q     <= pa.bus_hold ? program_counter_q : npa_d + 16'h0001;
			pmode_q               <= pmode_d;
			trap_taken_q          <= trap_ok;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			micro_stack_q <= RST_PA;
		end else if (pa.dseq_start & ~pa.bus_hold & ~trap_ok & ~pa.branch) begin
			micro_stack_q <= program_counter_q;
		end
	end

	// push shifts down, pop shifts up; the bottom entry is copied on pop
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < STK_DEPTH; i++) begin
				stk_q[i] <= 16'h0000;
			end
		end else if (stk_push) begin
			stk_q[0] <= stk_val;
			for (int i = 1; i < STK_DEPTH; i++) begin
				stk_q[i] <= stk_q[i-1];
			end
		end else if (pa.pop) begin
			for (int i = 0; i < STK_DEPTH - 1; i++) begin
				stk_q[i] <= stk_q[i+1];
			end
		end
	end

	assign stack_top_q = stk_q[0];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			temporary_operand_register_q <= 16'h0000;
			product_register_q           <= 32'h0000_0000;
			product_to_alu_q             <= 32'h0000_0000;
			input_scaled_q               <= 32'h0000_0000;
		end else begin
			if (ctl.ld_temporary_operand_register) begin
				temporary_operand_register_q <= rd_data;
			end
			if (ctl.multiplier_unit) begin
				product_register_q <= mpy_full[31:0];
			end
			product_to_alu_q <= psc_f(product_register_q, pm);
			if (ctl.isc) begin
				input_scaled_q <= isc_res;
			end
		end
	end

	// status store takes the bus over an accumulator store
	always_comb begin
		dw_d = data_write_bus_q;
		if (ctl.sst0) begin
			dw_d = status_word_0_q;
		end else if (ctl.sst1) begin
			dw_d = status_word_1_q;
		end else if (ctl.store) begin
			dw_d = osc_out;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			data_write_bus_q <= 16'h0000;
			data_write_en_q  <= 1'b0;
		end else begin
			data_write_bus_q <= dw_d;
			data_write_en_q  <= ctl.sst0 | ctl.sst1 | ctl.store;
		end
	end

	// order matters: later writes win, so an overflow event beats any clear
	always_comb begin
		st0_d = status_word_0_q;
		st1_d = status_word_1_q;
		if (ctl.lst0) begin
			st0_d = (rd_data & ~INTERRUPT_DISABLE_BIT_MASK) | (status_word_0_q & INTERRUPT_DISABLE_BIT_MASK);
		end
		if (ctl.lst1) begin
			st1_d = rd_data;
			st0_d[15:ST0_ARP_LSB] = rd_data[15:13];
		end
		if (ctl.set_control_bit_instruction | ctl.clear_control_bit_instruction) begin
			if (cpos[4]) begin
				st1_d[cpos[3:0]] = ctl.set_control_bit_instruction;
			end else begin
				st0_d[cpos[3:0]] = ctl.set_control_bit_instruction;
			end
		end
		if (ctl.dynamic_bit_test_instruction) begin
			st1_d[ST1_TC] = rd_data[dynamic_bit_test_instruction_idx];
		end
		if (trap_ok & pa.trap_maskable) begin
			st0_d[ST0_INTERRUPT_DISABLE_BIT] = 1'b1;
		end
		if (ctl.ov_clr) begin
			st0_d[ST0_OV] = 1'b0;
		end
		if (ctl.alu_ov) begin
			st0_d[ST0_OV] = 1'b1;
		end
		st0_d = st0_d | ST0_RSVD;
		st1_d = st1_d | ST1_RSVD;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			status_word_0_q        <= ST0_RST;
			status_word_1_q        <= ST1_RST;
			external_flag_output_q <= ST1_RST[ST1_XF];
		end else begin
			status_word_0_q        <= st0_d;
			status_word_1_q        <= st1_d;
			external_flag_output_q <= st1_d[ST1_XF];
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_RSVD_ONES: assert property (
		(status_word_0_q & ST0_RSVD) == ST0_RSVD && (status_word_1_q & ST1_RSVD) == ST1_RSVD)
		else $error("reserved status bit reads zero");

	AST_LST_KEEPS_INTERRUPT_DISABLE_BIT: assert property (
		ctl.lst0 && !trap_ok && !ctl.set_control_bit_instruction && !ctl.clear_control_bit_instruction |=> $stable(status_word_0_q[ST0_INTERRUPT_DISABLE_BIT]))
		else $error("status load changed interrupt-disable bit");

	AST_TRAP_SETS_INTERRUPT_DISABLE_BIT: assert property (
		trap_ok && pa.trap_maskable |=> status_word_0_q[ST0_INTERRUPT_DISABLE_BIT] && trap_taken_q)
		else $error("maskable trap did not disable interrupts");

	AST_MASKED_TRAP: assert property (
		pa.trap && pa.trap_maskable && interrupt_disable_bit |=> !trap_taken_q)
		else $error("maskable trap taken while disabled");

	AST_OV_STICKY: assert property (
		status_word_0_q[ST0_OV] && !ctl.lst0 && !ctl.ov_clr |=> status_word_0_q[ST0_OV])
		else $error("overflow flag dropped by itself");

	AST_OV_SET: assert property (
		ctl.alu_ov |=> status_word_0_q[ST0_OV])
		else $error("overflow event lost");

	AST_PAR_HOLD: assert property (
		pa.bus_hold [*2] |=> $stable(program_address_bus_q) && $stable(next_pa_q))
		else $error("address moved during bus hold");

	AST_PAR_FOLLOWS: assert property (
		!pa.bus_hold |=> program_address_bus_q == $past(next_pa_q))
		else $error("bus address is not the previous next address");

	AST_PC_INC: assert property (
		!pa.bus_hold |=> program_counter_q == next_pa_q + 16'h0001)
		else $error("counter is not next address plus one");

	AST_MPY_SIGNED: assert property (
		ctl.multiplier_unit && !ctl.mpy_unsigned |=>
		$signed(product_register_q) == $signed($past(temporary_operand_register_q)) * $signed($past(rd_data)))
		else $error("signed product wrong");

	AST_MICRO_STACK_SAVE: assert property (
		pa.dseq_start && !pa.bus_hold && !pa.trap && !pa.branch |=> micro_stack_q == $past(program_counter_q))
		else $error("micro stack did not save fetch address");

	AST_STK_PUSH: assert property (
		pa.push && !pa.trap |=> stack_top_q == $past(pa.push_data))
		else $error("stack push lost");

	AST_SET_CONTROL_BIT_INSTRUCTION_SXM: assert property (
		ctl.set_control_bit_instruction && ctl.cbit == CB_SXM && !ctl.lst1 |=> status_word_1_q[ST1_SXM]
		&& status_word_1_q[ST1_C] == $past(status_word_1_q[ST1_C]))
		else $error("set of one bit disturbed another");

	CV_TRAP: cover property (trap_ok ##1 trap_taken_q);
	CV_DSEQ: cover property (pa.dseq_start && !pa.bus_hold ##[1:20] seq_end && !pa.bus_hold);
	CV_MPY_PM: cover property (ctl.multiplier_unit ##1 pm == 2'h3);
endmodule

// ==== common/dcs_pkg.sv ====
package dcs_pkg;
	localparam int unsigned ST0_ARP_LSB  = 13;
	localparam int unsigned ST0_OV       = 12;
	localparam int unsigned ST0_OVM      = 11;
	localparam int unsigned ST0_INTERRUPT_DISABLE_BIT     = 9;
	localparam int unsigned ST1_CNF      = 12;
	localparam int unsigned ST1_TC       = 11;
	localparam int unsigned ST1_SXM      = 10;
	localparam int unsigned ST1_C        = 9;
	localparam int unsigned ST1_XF       = 4;
	localparam logic [15:0] ST0_RSVD     = 16'h0400;
	localparam logic [15:0] ST1_RSVD     = 16'h01ec;
	localparam logic [15:0] ST0_RST      = 16'h0600;
	localparam logic [15:0] ST1_RST      = 16'h03ec;
	localparam logic [15:0] INTERRUPT_DISABLE_BIT_MASK    = 16'h0200;
	localparam logic [1:0]  PM_NONE      = 2'h0;
	localparam logic [1:0]  PM_L1        = 2'h1;
	localparam logic [1:0]  PM_L4        = 2'h2;
	localparam int unsigned PS_L1        = 1;
	localparam int unsigned PS_L4        = 4;
	localparam int unsigned PS_R6        = 6;
	localparam logic [4:0]  ISC_MAX      = 5'h10;
	localparam logic [15:0] RST_PA       = 16'h0000;
	localparam logic [15:0] TRAP_BASE    = 16'h0000;
	localparam int unsigned TRAP_SHIFT   = 1;
	localparam int unsigned NUM_TRAPS    = 32;
	localparam int unsigned STK_DEPTH    = 8;

	typedef enum logic [2:0] {
		CB_OVM  = 3'h0,
		CB_INTERRUPT_DISABLE_BIT = 3'h1,
		CB_CNF  = 3'h2,
		CB_TC   = 3'h3,
		CB_SXM  = 3'h4,
		CB_C    = 3'h5,
		CB_XF   = 3'h6
	} dcs_cbit_t;

	typedef enum logic {
		PMODE_FETCH = 1'b0,
		PMODE_DATA  = 1'b1
	} dcs_pmode_t;

	typedef struct packed {
		logic        bus_hold;
		logic        branch;
		logic [15:0] br_addr;
		logic        dseq_start;
		logic [15:0] dseq_addr;
		logic        dseq_end;
		logic        trap;
		logic [4:0]  trap_num;
		logic        trap_maskable;
		logic        push;
		logic        pop;
		logic [15:0] push_data;
	} dcs_pa_t;

	typedef struct packed {
		logic        ld_temporary_operand_register;
		logic        multiplier_unit;
		logic        mpy_unsigned;
		logic        isc;
		logic        isc_by_temporary_operand_register;
		logic [4:0]  isc_cnt;
		logic        dynamic_bit_test_instruction;
		logic        store;
		logic        store_hi;
		logic [2:0]  osc_cnt;
		logic        lst0;
		logic        lst1;
		logic        sst0;
		logic        sst1;
		logic        set_control_bit_instruction;
		logic        clear_control_bit_instruction;
		dcs_cbit_t   cbit;
		logic        alu_ov;
		logic        ov_clr;
	} dcs_ctl_t;
endpackage

// ==== sim/dcs_mem_model.sv ====
`timescale 1ns/1ps
// data memory on the write bus side; logs every store so the bench can read back
module dcs_mem_model (
	input  wire logic        clk_sys,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	output logic      [15:0] last_wr,
	output int               wr_count
);
	logic [15:0] log_q[$];
	initial begin
		wr_count = 0;
		last_wr = 16'h0000;
	end
	// the write pulse lasts one cycle, so it is sampled on every edge
	always @(posedge clk_sys) begin
		if (wr_en === 1'b1) begin
			log_q.push_back(wr_data);
			last_wr <= wr_data;
			wr_count <= wr_count + 1;
		end
	end
endmodule

// ==== sim/dsp_core_datapath_status_tb.sv ====
`timescale 1ns/1ps
module dsp_core_datapath_status_tb;
	import dcs_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	dcs_pa_t     pa = '0;
	dcs_ctl_t    ctl = '0;
	logic [15:0] rd_data = 16'h0000;
	logic [31:0] acc = 32'h00000000;
	logic [15:0] program_address_bus, npa, pcq, mstk, stop, temporary_operand_register, s0, s1, dwb, mlast, e0, e1, t, b, k;
	logic        trap_q, dwe, xf, u;
	logic [31:0] product_register, palu, isc, p, e;
	int          fail_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          mcnt, i, pm, c;
	integer      seed = 32'hc01434c6;
	int          bitpos[7] = '{ST0_OVM, ST0_INTERRUPT_DISABLE_BIT, ST1_CNF, ST1_TC, ST1_SXM, ST1_C, ST1_XF};
	always #50 clk_sys = ~clk_sys;
	dcs_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .pa(pa), .ctl(ctl), .rd_data(rd_data), .acc(acc),
		.program_address_bus_q(program_address_bus), .next_pa_q(npa), .program_counter_q(pcq), .micro_stack_q(mstk),
		.stack_top_q(stop), .trap_taken_q(trap_q), .temporary_operand_register_q(temporary_operand_register),
		.product_register_q(product_register), .product_to_alu_q(palu), .input_scaled_q(isc),
		.data_write_bus_q(dwb), .data_write_en_q(dwe), .status_word_0_q(s0), .status_word_1_q(s1),
		.external_flag_output_q(xf));
	dcs_mem_model mem (.clk_sys(clk_sys), .wr_en(dwe), .wr_data(dwb), .last_wr(mlast), .wr_count(mcnt));
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] ex, logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, ex, got);
		end
	endtask
	// strobes last exactly one edge, then drop
	task automatic tick();
		@(posedge clk_sys);
		#10;
		pa = '0;
		ctl = '0;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		#10;
		rst_n = 1'b1;
		e0 = 16'h0600;
		e1 = 16'h03ec;
		chk("st0", e0, s0);
		chk("st1", e1, s1);
		pa.branch = 1'b1;
		pa.br_addr = 16'h1234;
		tick();
		chk("npa", 32'h1234, npa);
		chk("pc", 32'h1235, pcq);
		tick();
		chk("pab", 32'h1234, program_address_bus);
		pa.bus_hold = 1'b1;
		tick();
		chk("pab hold", 32'h1234, program_address_bus);
		pa.trap = 1'b1;
		pa.trap_num = 5'h03;
		pa.trap_maskable = 1'b1;
		tick();
		chk("trap masked", 0, trap_q);
		k = pcq;
		pa.trap = 1'b1;
		pa.trap_num = 5'h1f;
		tick();
		chk("trap", 1, trap_q);
		chk("vector", TRAP_BASE + (16'h1f << TRAP_SHIFT), npa);
		chk("ret addr", k, stop);
		for (i = 1; i <= 9; i++) begin
			pa.push = 1'b1;
			pa.push_data = 16'(i);
			tick();
		end
		// ninth push dropped the oldest; pops copy the bottom entry upward
		for (i = 1; i <= 8; i++) begin
			pa.pop = 1'b1;
			tick();
			chk("stack", (9 - i < 2) ? 2 : 9 - i, stop);
		end
		k = pcq;
		pa.dseq_start = 1'b1;
		pa.dseq_addr = 16'h0300;
		tick();
		chk("micro_stack", k, mstk);
		chk("data addr", 32'h0300, npa);
		pa.dseq_end = 1'b1;
		tick();
		chk("fetch resume", k, npa);
		for (i = 0; i < 4; i++) begin
			rd_data = 16'($random(seed));
			ctl.lst0 = 1'b1;
			tick();
			e0 = (rd_data & 16'hfdff) | (e0 & INTERRUPT_DISABLE_BIT_MASK) | ST0_RSVD;
			chk("lst0", e0, s0);
			rd_data = 16'($random(seed));
			ctl.lst1 = 1'b1;
			tick();
			e1 = rd_data | ST1_RSVD;
			e0 = (e0 & 16'h1fff) | (rd_data & 16'he000);
			chk("lst1", e1, s1);
			chk("arp", e0, s0);
			chk("xf", e1[4], xf);
		end
		for (i = 0; i < 28; i++) begin
			c = i % 7;
			ctl.cbit = dcs_cbit_t'(c);
			ctl.set_control_bit_instruction = (i < 14) ? i[0] : 1'b0;
			ctl.clear_control_bit_instruction = (i < 14) ? ~i[0] : 1'b1;
			tick();
			if (c < 2) e0[bitpos[c]] = (i < 14) ? i[0] : 1'b0;
			else e1[bitpos[c]] = (i < 14) ? i[0] : 1'b0;
			chk("st0 bit", e0, s0);
			chk("st1 bit", e1, s1);
		end
		pa.trap = 1'b1;
		pa.trap_maskable = 1'b1;
		pa.trap_num = 5'h07;
		tick();
		e0 = e0 | INTERRUPT_DISABLE_BIT_MASK;
		chk("trap ok", 1, trap_q);
		chk("interrupt_disable_bit", e0, s0);
		ctl.sst0 = 1'b1;
		tick();
		chk("sst0", e0, dwb);
		ctl.alu_ov = 1'b1;
		tick();
		tick();
		e0[ST0_OV] = 1'b1;
		chk("ov sticky", e0, s0);
		ctl.ov_clr = 1'b1;
		tick();
		e0[ST0_OV] = 1'b0;
		chk("ov clr", e0, s0);
		for (i = 0; i < 8; i++) begin
			pm = i % 4;
			rd_data = (e1 & 16'hfffc) | 16'(pm);
			ctl.lst1 = 1'b1;
			tick();
			e1 = rd_data;
			t = 16'($random(seed));
			b = 16'($random(seed));
			u = i[2];
			rd_data = t;
			ctl.ld_temporary_operand_register = 1'b1;
			tick();
			chk("temporary_operand_register", t, temporary_operand_register);
			rd_data = b;
			ctl.multiplier_unit = 1'b1;
			ctl.mpy_unsigned = u;
			tick();
			if (u) p = {16'h0000, t} * {16'h0000, b};
			else p = $signed(t) * $signed(b);
			chk("product_register", p, product_register);
			tick();
			case (pm)
				0: e = p;
				1: e = p << PS_L1;
				2: e = p << PS_L4;
				default: e = $signed(p) >>> PS_R6;
			endcase
			chk("product_scaling_shifter", e, palu);
			chk("product_register held", p, product_register);
		end
		rd_data = 16'($random(seed));
		ctl.dynamic_bit_test_instruction = 1'b1;
		tick();
		chk("dynamic_bit_test_instruction", rd_data[4'hf - t[3:0]], s1[ST1_TC]);
		ctl.isc = 1'b1;
		ctl.isc_by_temporary_operand_register = 1'b1;
		tick();
		chk("input_scaling_shifter temporary_operand_register", {16'h0000, rd_data} << t[3:0], isc);
		for (i = 0; i < 17; i++) begin
			rd_data = 16'($random(seed));
			ctl.isc = 1'b1;
			ctl.isc_cnt = 5'(i);
			tick();
			chk("input_scaling_shifter", {16'h0000, rd_data} << i, isc);
		end
		for (i = 0; i < 16; i++) begin
			acc = $random(seed);
			ctl.store = 1'b1;
			ctl.store_hi = i[0];
			ctl.osc_cnt = 3'(i >> 1);
			tick();
			e = acc << (i >> 1);
			chk("output_scaling_shifter", i[0] ? e[31:16] : e[15:0], dwb);
			tick();
			chk("mem", i[0] ? e[31:16] : e[15:0], mlast);
		end
		complete_run();
	end
endmodule
